// file: design/dual_dac_backend_cfg.svh
// Register offsets, field positions, reset values and constants of the converter back end
`ifndef DUAL_DAC_BACKEND_CFG_SVH
`define DUAL_DAC_BACKEND_CFG_SVH

// Word byte addresses
`define ADDR_COMMON        8'h00
`define ADDR_OSC_FREQ_WORD 8'h04
`define ADDR_OSC_PHASE     8'h08
`define ADDR_CHAN_A_GAIN   8'h0c
`define ADDR_CHAN_B_GAIN   8'h10
`define ADDR_CHAN_A_OFFSET 8'h14
`define ADDR_CHAN_B_OFFSET 8'h18
`define ADDR_AUX_A         8'h1c
`define ADDR_AUX_B         8'h20
`define ADDR_PHASE_ACC     8'h24

// Common register fields
`define BIT_BANDGAP_OFF    0
`define BIT_TWOS_COMP      2
`define BIT_LOW_POWER_OSC  3
`define BIT_SIDEBAND_INV   4
`define BIT_GAIN_CUT       5
`define BIT_INV_SINC_EN    6

// Gain register fields
`define FINE_LSB           0
`define COARSE_LSB         8

// Reset values
`define COMMON_RESET       8'h00
`define COARSE_RESET       4'hd
`define FINE_RESET         6'h00
`define OFFSET_RESET       12'h000
`define AUX_RESET          10'h000

// Inverse-sinc taps
`define TAP_0              12'sd2
`define TAP_1              -12'sd4
`define TAP_2              12'sd10
`define TAP_3              -12'sd35
`define TAP_C              12'sd401

// Minus 3 dB factor: 181/256 = 0.707
`define GAIN_CUT_MUL       9'sd181
`define SINC_TAPS          9

`endif

// file: design/dual_dac_backend_pkg.sv
// Types shared by the converter back end
package dual_dac_backend_pkg;
    typedef logic signed [11:0] sample_type;
    typedef logic [3:0]         coarse_type;
    typedef logic [5:0]         fine_type;
endpackage : dual_dac_backend_pkg

// file: design/dual_dac_modulator_backend.sv
// Digital back end: oscillator, modulator, inverse sinc, gain, offset, aux
//
// Operation
// - Mix 12-bit I and Q with oscillator cosine and sine.
// - A setting inverts sine sign for lower or upper sideband.
// - Full mode: 32-bit frequency word from four bytes, f = M*fs/2^32.
// - Start phase is 16 bits over two bytes covering full circle.
// - Low-power mode uses only top five frequency bits, f = M*fs/32.
// - Low-power phase uses only top five bits of upper phase byte.
// - Gain-cut option lowers modulator gain by 3 dB.
// - Optional nine-tap symmetric inverse-sinc filter 2,-4,10,-35,401.
// - Inverse-sinc path carries 3.4 dB DC loss versus bypass.
// - Common bit 2 selects offset binary or two's complement input.
// - Codes map min, mid and max as binary or two's complement.
// - Positive output is code/4095, negative output carries remainder.
// - Common bit 0 powers down bandgap for external reference.
// - Per channel 4-bit coarse gain, default 1101 gives 20 mA.
// - Per channel 6-bit fine gain in second configuration register.
// - Fine gain code is two's complement from -32 to +31.
// - Per channel digital offset added just before converter core.
// - Offset is two's complement -1024 to +1023, default zero.
// - Two 10-bit aux converters, outputs code/1023 and complement.
//
// Design decisions made here: the address map and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "dual_dac_backend_cfg.svh"

module dual_dac_modulator_backend
    import dual_dac_backend_pkg::*;
(
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        rst_n_in,
    // Wishbone slave
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [7:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic      [31:0] wb_dat_out,
    output logic             wb_ack_out,
    // Interpolated samples, one per clock
    input  wire logic [11:0] i_sample_in,
    input  wire logic [11:0] q_sample_in,
    // Converter core codes, unsigned 0..4095
    output logic      [11:0] chan_a_code_out,
    output logic      [11:0] chan_b_code_out,
    // Analog control
    output logic             bandgap_off_out,
    output logic      [3:0]  chan_a_coarse_out,
    output logic      [5:0]  chan_a_fine_out,
    output logic      [3:0]  chan_b_coarse_out,
    output logic      [5:0]  chan_b_fine_out,
    output logic      [9:0]  aux_a_code_out,
    output logic      [9:0]  aux_b_code_out
);

    logic [7:0]       common_q;
    logic [31:0]      osc_freq_word_q;
    logic [15:0]      osc_phase_q;
    logic [9:0]       gain_a_q;
    logic [9:0]       gain_b_q;
    logic [11:0]      offset_a_q;
    logic [11:0]      offset_b_q;
    logic [9:0]       aux_a_q;
    logic [9:0]       aux_b_q;
    logic [31:0]      phase_acc_q;
    logic             ack_q;
    logic             wb_req;
    logic             wb_wr;

    assign wb_req = wb_cyc_in && wb_stb_in && !ack_q;
    assign wb_wr  = wb_req && wb_we_in;

    // Byte-lane merge so partial writes keep the other lanes
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction : merge

    // Ack one cycle after request, dropped the next
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_req;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wb_dat_out <= 32'h0000_0000;
        end else if (wb_req) begin
            case (wb_adr_in)
                `ADDR_COMMON:        wb_dat_out <= {24'h0, common_q};
                `ADDR_OSC_FREQ_WORD: wb_dat_out <= osc_freq_word_q;
                `ADDR_OSC_PHASE:     wb_dat_out <= {16'h0, osc_phase_q};
                `ADDR_CHAN_A_GAIN:   wb_dat_out <= {20'h0, gain_a_q[9:6],
                                                    2'h0, gain_a_q[5:0]};
                `ADDR_CHAN_B_GAIN:   wb_dat_out <= {20'h0, gain_b_q[9:6],
                                                    2'h0, gain_b_q[5:0]};
                `ADDR_CHAN_A_OFFSET: wb_dat_out <= {20'h0, offset_a_q};
                `ADDR_CHAN_B_OFFSET: wb_dat_out <= {20'h0, offset_b_q};
                `ADDR_AUX_A:         wb_dat_out <= {22'h0, aux_a_q};
                `ADDR_AUX_B:         wb_dat_out <= {22'h0, aux_b_q};
                `ADDR_PHASE_ACC:     wb_dat_out <= phase_acc_q;
                default:             wb_dat_out <= 32'h0000_0000;
            endcase
        end
    end
    assign wb_ack_out = ack_q;

    // Register writes
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            common_q        <= `COMMON_RESET;
            osc_freq_word_q <= 32'h0000_0000;
            osc_phase_q     <= 16'h0000;
            gain_a_q        <= {`COARSE_RESET, `FINE_RESET};
            gain_b_q        <= {`COARSE_RESET, `FINE_RESET};
            offset_a_q      <= `OFFSET_RESET;
            offset_b_q      <= `OFFSET_RESET;
            aux_a_q         <= `AUX_RESET;
            aux_b_q         <= `AUX_RESET;
        end else if (wb_wr) begin
            case (wb_adr_in)
                `ADDR_COMMON: begin
                    if (wb_sel_in[0]) common_q <= wb_dat_in[7:0];
                end
                `ADDR_OSC_FREQ_WORD: begin
                    // Four byte lanes are the four frequency bytes
                    osc_freq_word_q <= merge(osc_freq_word_q, wb_dat_in,
                                             wb_sel_in);
                end
                `ADDR_OSC_PHASE: begin
                    osc_phase_q <= 16'(merge({16'h0, osc_phase_q},
                                             wb_dat_in,
                                             wb_sel_in));
                end
                `ADDR_CHAN_A_GAIN: begin
                    if (wb_sel_in[0]) gain_a_q[5:0] <= wb_dat_in[5:0];
                    if (wb_sel_in[1]) gain_a_q[9:6] <= wb_dat_in[11:8];
                end
                `ADDR_CHAN_B_GAIN: begin
                    if (wb_sel_in[0]) gain_b_q[5:0] <= wb_dat_in[5:0];
                    if (wb_sel_in[1]) gain_b_q[9:6] <= wb_dat_in[11:8];
                end
                `ADDR_CHAN_A_OFFSET: begin
                    offset_a_q <= 12'(merge({20'h0, offset_a_q},
                                            wb_dat_in, wb_sel_in));
                end
                `ADDR_CHAN_B_OFFSET: begin
                    offset_b_q <= 12'(merge({20'h0, offset_b_q},
                                            wb_dat_in, wb_sel_in));
                end
                `ADDR_AUX_A: begin
                    aux_a_q <= 10'(merge({22'h0, aux_a_q},
                                         wb_dat_in, wb_sel_in));
                end
                `ADDR_AUX_B: begin
                    aux_b_q <= 10'(merge({22'h0, aux_b_q},
                                         wb_dat_in, wb_sel_in));
                end
                default: begin
                end
            endcase
        end
    end

    // Oscillator
    logic        low_power;
    logic [31:0] phase_step;
    logic [31:0] phase_sum;
    logic [31:0] phase_now;
    logic [7:0]  angle;

    assign low_power = common_q[`BIT_LOW_POWER_OSC];
    // Low power keeps only the top five bits of word and phase
    assign phase_step = low_power ? {osc_freq_word_q[31:27], 27'h0}
                                  : osc_freq_word_q;
    assign phase_now  = low_power ? {osc_phase_q[15:11], 27'h0}
                                  : {osc_phase_q, 16'h0};
    assign phase_sum  = phase_acc_q + phase_now;
    assign angle      = phase_sum[31:24];

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phase_acc_q <= 32'h0000_0000;
        end else begin
            phase_acc_q <= phase_acc_q + phase_step;
        end
    end

    // Quarter-wave free sine: 256-point table built by a function
    function automatic logic signed [11:0] sine_of(input logic [7:0] a);
        real v;
        v = $sin(2.0 * 3.14159265358979 * real'(a) / 256.0) * 2047.0;
        return 12'($rtoi(v));
    endfunction : sine_of

    logic signed [11:0] sine_rom [256];
    for (genvar k = 0; k < 256; k++) begin : g_rom
        assign sine_rom[k] = sine_of(8'(k));
    end

    logic signed [11:0] sin_v;
    logic signed [11:0] cos_v;
    assign cos_v = sine_rom[8'(angle + 8'h40)];
    assign sin_v = common_q[`BIT_SIDEBAND_INV] ? -sine_rom[angle]
                                               : sine_rom[angle];

    // Input format: flip MSB to turn offset binary into signed
    sample_type i_s;
    sample_type q_s;
    assign i_s = common_q[`BIT_TWOS_COMP] ? i_sample_in
                 : {~i_sample_in[11], i_sample_in[10:0]};
    assign q_s = common_q[`BIT_TWOS_COMP] ? q_sample_in
                 : {~q_sample_in[11], q_sample_in[10:0]};

    // Modulator: i*cos - q*sin, scaled back to 12 bits
    logic signed [24:0] mix_full;
    logic signed [33:0] mix_cut;
    logic signed [13:0] mix_d;
    logic signed [13:0] mix_q;
    assign mix_full = 25'(i_s * cos_v) - 25'(q_s * sin_v);
    assign mix_cut  = mix_full * `GAIN_CUT_MUL;
    assign mix_d    = common_q[`BIT_GAIN_CUT] ? 14'(mix_cut >>> 19)
                                              : 14'(mix_full >>> 11);

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mix_q <= 14'sh0;
        end else begin
            mix_q <= mix_d;
        end
    end

    // Saturate modulator output to 12 bits
    sample_type mod_s;
    assign mod_s = (mix_q > 14'sd2047) ? 12'sh7ff
                 : (mix_q < -14'sd2048) ? 12'sh800 : 12'(mix_q);

    // Inverse-sinc filter; taps sum to 347, shift by 9 gives 3.4 dB loss
    sample_type sinc_q [`SINC_TAPS];
    for (genvar t = 0; t < `SINC_TAPS; t++) begin : g_line
        always_ff @(posedge clock_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                sinc_q[t] <= 12'sh0;
            end else begin
                sinc_q[t] <= (t == 0) ? mod_s : sinc_q[(t == 0) ? 0 : t - 1];
            end
        end
    end

    logic signed [23:0] fir_acc;
    assign fir_acc = 24'(`TAP_0 * (sinc_q[0] + 13'(sinc_q[8])))
                   + 24'(`TAP_1 * (sinc_q[1] + 13'(sinc_q[7])))
                   + 24'(`TAP_2 * (sinc_q[2] + 13'(sinc_q[6])))
                   + 24'(`TAP_3 * (sinc_q[3] + 13'(sinc_q[5])))
                   + 24'(`TAP_C * sinc_q[4]);

    sample_type path_s;
    assign path_s = common_q[`BIT_INV_SINC_EN] ? 12'(fir_acc >>> 9)
                                               : sinc_q[4];

    // Offset before core, then back to unsigned code 0..4095
    function automatic logic [11:0] offset_code(input sample_type s,
                                                input logic [11:0] off);
        logic signed [13:0] v;
        v = 14'(s) + 14'($signed(off[10:0]));
        if (v > 14'sd2047) v = 14'sd2047;
        if (v < -14'sd2048) v = -14'sd2048;
        return {~v[11], v[10:0]};
    endfunction : offset_code

    // Channel A takes the modulated path, channel B its quadrature
    logic signed [24:0] quad_full;
    sample_type quad_s;
    assign quad_full = 25'(i_s * sin_v) + 25'(q_s * cos_v);
    assign quad_s    = 12'(quad_full >>> 12);

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            chan_a_code_out <= 12'h800;
            chan_b_code_out <= 12'h800;
        end else begin
            chan_a_code_out <= offset_code(path_s, offset_a_q);
            chan_b_code_out <= offset_code(quad_s, offset_b_q);
        end
    end

    // Analog controls straight from registers
    assign bandgap_off_out   = common_q[`BIT_BANDGAP_OFF];
    assign chan_a_coarse_out = gain_a_q[9:6];
    assign chan_a_fine_out   = gain_a_q[5:0];
    assign chan_b_coarse_out = gain_b_q[9:6];
    assign chan_b_fine_out   = gain_b_q[5:0];
    assign aux_a_code_out    = aux_a_q;
    assign aux_b_code_out    = aux_b_q;

endmodule : dual_dac_modulator_backend
`default_nettype wire

// file: tb/baseband_source.sv
// Baseband sample source: constant-level I, zero Q, in the chosen format
`timescale 1ns/1ps
`default_nettype none

module baseband_source (
    // Clock and control
    input  wire logic        clock_in,
    input  wire logic        rst_n_in,
    input  wire logic        twos_in,
    input  wire logic [11:0] level_in,
    // Samples
    output logic      [11:0] i_out,
    output logic      [11:0] q_out
);
    // A DC level on I with Q at zero keeps the mixed codes predictable
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            i_out <= 12'h800;
            q_out <= 12'h800;
        end else begin
            i_out <= twos_in ? level_in
                             : {~level_in[11], level_in[10:0]};
            q_out <= twos_in ? 12'h000 : 12'h800;
        end
    end
endmodule : baseband_source

`default_nettype wire

// file: tb/dual_dac_backend_checker.sv
// Port-level assertions for the converter back end
`timescale 1ns/1ps
`default_nettype none

module dual_dac_backend_checker (
    // Clock, reset and bus
    input wire logic        clock_in,
    input wire logic        rst_n_in,
    input wire logic        wb_cyc_in,
    input wire logic        wb_stb_in,
    input wire logic        wb_we_in,
    input wire logic [7:0]  wb_adr_in,
    input wire logic [3:0]  wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic        wb_ack_out,
    // Register-driven levels
    input wire logic        bandgap_off_out,
    input wire logic [3:0]  chan_a_coarse_out,
    input wire logic [5:0]  chan_b_fine_out,
    input wire logic [9:0]  aux_a_code_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    logic take;
    logic wr;
    assign take = wb_cyc_in && wb_stb_in && !wb_ack_out;
    assign wr   = take && wb_we_in;

    chk_ack_one_pulse: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack held longer than one cycle");
    chk_ack_follows_req: assert property (take |=> wb_ack_out)
        else $error("ack missing one cycle after request");
    chk_ack_has_cause: assert property (wb_ack_out |-> $past(take))
        else $error("ack without a request");
    chk_bandgap_write: assert property (wr && wb_adr_in == 8'h00 &&
        wb_sel_in[0] |=> bandgap_off_out == $past(wb_dat_in[0]))
        else $error("bandgap control not written");
    chk_coarse_write: assert property (wr && wb_adr_in == 8'h0c &&
        wb_sel_in[1] |=> chan_a_coarse_out == $past(wb_dat_in[11:8]))
        else $error("coarse gain not written");
    chk_aux_write: assert property (wr && wb_adr_in == 8'h1c &&
        wb_sel_in[1:0] == 2'h3 |=> aux_a_code_out == $past(wb_dat_in[9:0]))
        else $error("aux code not written");
    chk_coarse_holds: assert property (
        !wr |=> $stable(chan_a_coarse_out))
        else $error("coarse gain changed without write");
    chk_fine_holds: assert property (
        !wr |=> $stable(chan_b_fine_out))
        else $error("fine gain changed without write");
    chk_unmapped_zero: assert property (take && !wb_we_in &&
        wb_adr_in == 8'h28 |=> wb_dat_out == 32'h0000_0000)
        else $error("unmapped read not zero");
endmodule : dual_dac_backend_checker

bind dual_dac_modulator_backend dual_dac_backend_checker u_checker (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .bandgap_off_out(bandgap_off_out),
    .chan_a_coarse_out(chan_a_coarse_out),
    .chan_b_fine_out(chan_b_fine_out), .aux_a_code_out(aux_a_code_out));

`default_nettype wire

// file: tb/dual_dac_modulator_backend_tb.sv
// Self-checking bench for the converter back end
`timescale 1ns/1ps
`default_nettype none

module dual_dac_modulator_backend_tb;
    import dual_dac_backend_pkg::*;
    logic        clock_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, twos = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat_out, rd, a0, a1, a2;
    logic        ack;
    logic [11:0] i_s, q_s, code_a, code_b;
    logic [11:0] lvl = 12'h000, full_a, got_a;
    logic [9:0]  aux_a, aux_b;
    coarse_type  co_a, co_b;
    fine_type    fi_a, fi_b;
    logic        gap;
    int          err_total = 0;
    int          tests_run = 0;

    initial forever #25 clock_in = ~clock_in;

    dual_dac_modulator_backend DUT (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
        .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat_out),
        .wb_ack_out(ack), .i_sample_in(i_s), .q_sample_in(q_s),
        .chan_a_code_out(code_a), .chan_b_code_out(code_b),
        .bandgap_off_out(gap), .chan_a_coarse_out(co_a),
        .chan_a_fine_out(fi_a), .chan_b_coarse_out(co_b),
        .chan_b_fine_out(fi_b), .aux_a_code_out(aux_a),
        .aux_b_code_out(aux_b));

    baseband_source src (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .twos_in(twos), .level_in(lvl), .i_out(i_s), .q_out(q_s));

    task automatic results;
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One classic cycle; read data is taken at the edge that shows ack
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        int n;
        @(posedge clock_in);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hf; wdat <= d;
        for (n = 0; n < 16; n++) begin
            @(posedge clock_in);
            if (ack === 1'b1) break;
        end
        if (n == 16) begin
            chk("ack wait", 32'h1, 32'h0);
            results();
        end
        rd = rdat_out;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask : xfer

    // The datapath needs up to eleven cycles with inverse sinc on; wait well past that
    task automatic settle;
        repeat (16) @(posedge clock_in);
    endtask : settle

    // True when v lies between lo and hi percent of r
    function automatic logic in_pct(input logic [31:0] v,
                                    input logic [31:0] r,
                                    input logic [31:0] lo,
                                    input logic [31:0] hi);
        return (v * 100 >= r * lo) && (v * 100 <= r * hi);
    endfunction : in_pct

    // Let old codes drain first, then poll under a bound
    task automatic codes(input logic [11:0] ea, input logic [11:0] eb);
        settle();
        for (int n = 0; n < 64; n++) begin
            @(posedge clock_in);
            if (code_a === ea && code_b === eb) break;
        end
        chk("code a", {20'h0, ea}, {20'h0, code_a});
        chk("code b", {20'h0, eb}, {20'h0, code_b});
    endtask : codes

    initial begin
        repeat (8) @(posedge clock_in);
        chk("reset code", 32'h800, {20'h0, code_a});
        chk("reset coarse", 32'hd, {28'h0, co_b});
        chk("reset fine", 32'h0, {26'h0, fi_a});
        chk("reset aux", 32'h0, {22'h0, aux_b});
        chk("reset bandgap", 32'h0, {31'h0, gap});
        repeat (8) @(posedge clock_in);
        rst_n_in <= 1'b1;
        $display("Test reset done");

        xfer(1'b1, 8'h00, 32'h0000_0001);
        chk("bandgap off", 32'h1, {31'h0, gap});
        xfer(1'b1, 8'h0c, 32'h0000_0f1f);
        xfer(1'b1, 8'h10, 32'h0000_0020);
        chk("coarse a max", 32'hf, {28'h0, co_a});
        chk("fine a max", 32'h1f, {26'h0, fi_a});
        chk("coarse b min", 32'h0, {28'h0, co_b});
        chk("fine b min", 32'h20, {26'h0, fi_b});
        xfer(1'b0, 8'h0c, 32'h0);
        chk("gain a read", 32'h0000_0f1f, rd);
        xfer(1'b1, 8'h1c, 32'h0000_03ff);
        xfer(1'b1, 8'h20, 32'h0000_0200);
        chk("aux a", 32'h3ff, {22'h0, aux_a});
        chk("aux b", 32'h200, {22'h0, aux_b});
        xfer(1'b1, 8'h28, 32'hffff_ffff);
        xfer(1'b0, 8'h28, 32'h0);
        chk("unmapped read", 32'h0, rd);
        $display("Test registers done");

        xfer(1'b1, 8'h00, 32'h0000_0004);
        twos <= 1'b1;
        xfer(1'b1, 8'h14, 32'h0000_03ff);
        xfer(1'b1, 8'h18, 32'h0000_0400);
        codes(12'hbff, 12'h400);
        xfer(1'b1, 8'h00, 32'h0000_0000);
        twos <= 1'b0;
        codes(12'hbff, 12'h400);
        xfer(1'b1, 8'h14, 32'h0000_0000);
        xfer(1'b1, 8'h18, 32'h0000_0fff);
        codes(12'h800, 12'h7ff);
        $display("Test offset done");

        // Constant I, zero Q, carrier at angle zero: B shows only its offset
        lvl <= 12'h400;
        settle();
        full_a = code_a - 12'h800;
        chk("mod full", 32'h1, {31'h0, in_pct(full_a, 1024, 99, 100)});
        chk("quad b zero", 32'h7ff, {20'h0, code_b});
        xfer(1'b1, 8'h00, 32'h0000_0020);
        settle();
        got_a = code_a - 12'h800;
        chk("gain cut", 32'h1, {31'h0, in_pct(got_a, full_a, 69, 72)});
        xfer(1'b1, 8'h00, 32'h0000_0040);
        settle();
        got_a = code_a - 12'h800;
        chk("sinc", 32'h1, {31'h0, in_pct(got_a, full_a, 66, 69)});
        // Carrier at 90 degrees: A sees no I, B carries it with sine sign
        xfer(1'b1, 8'h00, 32'h0000_0000);
        xfer(1'b1, 8'h08, 32'h0000_4000);
        settle();
        chk("quad a", 32'h800, {20'h0, code_a});
        chk("upper side", 32'h1, {31'h0, code_b > 12'h7ff});
        xfer(1'b1, 8'h00, 32'h0000_0010);
        settle();
        chk("lower side", 32'h1, {31'h0, code_b < 12'h7ff});
        // Low power ignores the phase bits below the top five
        xfer(1'b1, 8'h08, 32'h0000_47ff);
        xfer(1'b1, 8'h00, 32'h0000_0008);
        settle();
        chk("low power phase", 32'h800, {20'h0, code_a});
        xfer(1'b0, 8'h08, 32'h0);
        chk("phase read", 32'h0000_47ff, rd);
        lvl <= 12'h000;
        xfer(1'b1, 8'h00, 32'h0000_0000);
        $display("Test modulator done");

        // Reads three cycles apart see three steps of the word
        xfer(1'b1, 8'h04, 32'h0800_1000);
        xfer(1'b0, 8'h04, 32'h0);
        chk("freq read", 32'h0800_1000, rd);
        xfer(1'b0, 8'h24, 32'h0);
        a0 = rd;
        xfer(1'b0, 8'h24, 32'h0);
        a1 = rd;
        xfer(1'b0, 8'h24, 32'h0);
        a2 = rd;
        chk("acc step", 32'h1800_3000, a1 - a0);
        chk("acc step next", 32'h1800_3000, a2 - a1);
        chk("acc moving", 32'h1, {31'h0, a1 !== a0});
        xfer(1'b1, 8'h00, 32'h0000_0008);
        xfer(1'b0, 8'h24, 32'h0);
        a0 = rd;
        xfer(1'b0, 8'h24, 32'h0);
        a1 = rd;
        chk("low power step", 32'h1800_0000, a1 - a0);
        $display("Test oscillator done");

        rst_n_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        chk("rerun coarse", 32'hd, {28'h0, co_a});
        chk("rerun code", 32'h800, {20'h0, code_b});
        rst_n_in <= 1'b1;
        $display("Test reset again done");
        results();
    end

    initial begin
        #5000000;
        err_total++;
        results();
    end
endmodule : dual_dac_modulator_backend_tb

`default_nettype wire
